// *** hw/pan_pkg.sv ***
// package: constants and carrier types of the auto-negotiation block
package pan_pkg;
    // ********************************
    // clock and timing
    // ********************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int FLP_SLOT_NS = 62500;
    localparam int FLP_SLOT_CYC = FLP_SLOT_NS / CLK_PERIOD_NS;
    localparam int FLP_PULSE_NS = 100;
    localparam int FLP_PULSE_CYC = (FLP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLP_DATA_MAX_NS = 100000;
    localparam int FLP_DATA_MAX_CYC = FLP_DATA_MAX_NS / CLK_PERIOD_NS;
    localparam int FLP_INTERVAL_US = 16000;
    localparam int FLP_INTERVAL_SLOTS = FLP_INTERVAL_US * 1000 / FLP_SLOT_NS;
    localparam int FLP_BURST_SLOTS = 33;
    localparam int FLP_WORD_BITS = 16;
    localparam int FLP_RX_END_US = 1000;
    localparam int FLP_RX_END_CYC = FLP_RX_END_US * 1000 / CLK_PERIOD_NS;
    localparam logic [1:0] MATCH_COUNT = 2'h3;
    // ********************************
    // management registers
    // ********************************
    localparam logic [9:0] REG_CTRL = 10'h000;
    localparam logic [9:0] REG_STAT = 10'h001;
    localparam logic [9:0] REG_ADV = 10'h004;
    localparam logic [9:0] REG_LPA = 10'h005;
    localparam int CTRL_SPEED = 13;
    localparam int CTRL_AN_EN = 12;
    localparam int CTRL_RESTART = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int STAT_AN_DONE = 5;
    localparam int STAT_RFAULT = 4;
    localparam int STAT_LINK = 2;
    localparam logic [15:0] STAT_FIXED = 16'hF809;
    localparam int ABIL_100F = 8;
    localparam int ABIL_100H = 7;
    localparam int ABIL_10F = 6;
    localparam int ABIL_10H = 5;
    localparam int ADV_ACK = 14;
    localparam int ADV_RFAULT = 13;
    localparam logic [15:0] ADV_RESET = 16'h01E1;
    localparam logic [15:0] ADV_SELECTOR = 16'h0001;
    // ********************************
    // serial management frame
    // ********************************
    localparam logic [1:0] SMI_OP_READ = 2'h2;
    localparam logic [1:0] SMI_OP_WRITE = 2'h1;
    localparam logic [4:0] SMI_ADDR_LAST = 5'h09;
    localparam logic [4:0] SMI_DATA_LAST = 5'h0F;
    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic an_enable;
        logic speed_100;
        logic full_duplex;
        logic [1:0] port5_bus_select;
        logic port5_speed_strap;
        logic port5_duplex_strap;
        logic port5_link_strap;
        logic port4_pcs_select_strap;
        logic [1:0] port4_bus_select;
    } pan_strap_type;
    typedef struct packed {
        logic speed_100;
        logic full_duplex;
    } pan_mode_type;
    typedef struct packed {
        logic mii;
        logic speed_100;
        logic full_duplex;
        logic link_up;
    } pan_port5_type;
    typedef enum logic [1:0] {P4_PHY, P4_MAC_MII, P4_PCS_MII} pan_port4_type;
    typedef enum logic [1:0] {AN_OFF, AN_ABILITY, AN_ACK, AN_DONE} pan_an_state_type;
    typedef enum logic [2:0] {SM_IDLE, SM_START, SM_OP, SM_ADDR, SM_TA, SM_DATA} pan_smi_state_type;
endpackage : pan_pkg

// *** hw/pan_autoneg.sv ***
// module: auto-negotiation, speed/duplex control and strap decoding of one phy channel
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - disabled negotiation waits for enable bit 12
// - enabling negotiation starts it immediately
// - send advertisement register as fast link pulses
// - store partner abilities on completion
// - resolve highest common mode, 100F first
// - control register enables, disables, restarts negotiation
// - bits 13 and 8 force speed, duplex
// - enable bit set ignores forced speed/duplex
// - status reports fixed ability bits as ones
// - status bit 5 shows negotiation complete
// - status bit 4 shows partner remote fault
// - status bit 2 shows valid link
// - advertise all; writes or straps remove abilities
// - straps latched into advertisement at reset
// - straps set control defaults per table
// - port 5 bus select 00 means mii
// - port 5 speed strap low means 100
// - port 5 duplex strap low means full
// - port 5 link strap low forces link up
// - port 4 pcs strap high selects pcs mii
// - two-wire serial frames reach management registers
module pan_autoneg #(
    parameter int SLOT_CYC = pan_pkg::FLP_SLOT_CYC,
    parameter int INTERVAL_SLOTS = pan_pkg::FLP_INTERVAL_SLOTS,
    parameter int RX_END_CYC = pan_pkg::FLP_RX_END_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire pan_pkg::pan_strap_type straps_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_n_o,
    input wire logic flp_rx_i,
    output logic flp_tx_o,
    input wire logic link_ok_i,
    output pan_pkg::pan_mode_type mode_o,
    output pan_pkg::pan_port5_type port5_o,
    output pan_pkg::pan_port4_type port4_mode_o
);
    import pan_pkg::*;

    // ********************************
    // strap latch
    // ********************************
    pan_strap_type strap_r, strap_nxt;
    pan_port5_type port5_r, port5_nxt;
    pan_port4_type port4_r, port4_nxt;
    logic [15:0] strap_mask;

    always_comb
    begin
        strap_nxt = reset_i ? straps_i : strap_r;
        port5_nxt.mii = (strap_r.port5_bus_select == 2'h0);
        port5_nxt.speed_100 = ~strap_r.port5_speed_strap;
        port5_nxt.full_duplex = ~strap_r.port5_duplex_strap;
        port5_nxt.link_up = ~strap_r.port5_link_strap;
        if (strap_r.port4_pcs_select_strap)
            port4_nxt = P4_PCS_MII;
        else if (strap_r.port4_bus_select == 2'h1)
            port4_nxt = P4_MAC_MII;
        else
            port4_nxt = P4_PHY;
        // with negotiation on the straps remove abilities, with it off one mode stands
        strap_mask = ADV_SELECTOR | 16'(16'hFE00);
        if (strap_r.an_enable)
        begin
            strap_mask[ABIL_100F] = strap_r.speed_100 & strap_r.full_duplex;
            strap_mask[ABIL_100H] = strap_r.speed_100;
            strap_mask[ABIL_10F] = strap_r.full_duplex;
            strap_mask[ABIL_10H] = 1'b1;
        end
        else
        begin
            strap_mask[ABIL_100F] = strap_r.speed_100 & strap_r.full_duplex;
            strap_mask[ABIL_100H] = strap_r.speed_100 & ~strap_r.full_duplex;
            strap_mask[ABIL_10F] = ~strap_r.speed_100 & strap_r.full_duplex;
            strap_mask[ABIL_10H] = ~strap_r.speed_100 & ~strap_r.full_duplex;
        end
    end

    always_ff @(posedge clk_i)
    begin
        strap_r <= strap_nxt;
        port5_r <= port5_nxt;
        port4_r <= port4_nxt;
    end

    // ********************************
    // management serial port and registers
    // ********************************
    pan_smi_state_type sm_r, sm_nxt;
    logic mdc_q_r, mdc_q_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [1:0] op_r, op_nxt;
    logic [9:0] addr_r, addr_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [15:0] adv_r, adv_nxt;
    logic restart_r, restart_nxt;
    logic mdio_r, mdio_nxt;
    logic oe_n_r, oe_n_nxt;
    logic mdc_rise;
    logic [15:0] adv_eff;
    logic [15:0] stat_val;
    logic [15:0] lpa_r;
    logic an_done;
    logic link_r;

    always_comb
    begin
        mdc_rise = mdc_i & ~mdc_q_r;
        adv_eff = adv_r & strap_mask;
        stat_val = STAT_FIXED;
        stat_val[STAT_AN_DONE] = an_done;
        stat_val[STAT_RFAULT] = an_done & lpa_r[ADV_RFAULT];
        stat_val[STAT_LINK] = link_r;
        mdc_q_nxt = mdc_i;
        sm_nxt = sm_r;
        cnt_nxt = cnt_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        sh_nxt = sh_r;
        ctrl_nxt = ctrl_r;
        adv_nxt = adv_r;
        restart_nxt = 1'b0;
        if (mdc_rise)
        begin
            cnt_nxt = cnt_r + 5'h01;
            case (sm_r)
                SM_IDLE:
                    if (!mdio_i)
                        sm_nxt = SM_START;
                SM_START:
                begin
                    sm_nxt = mdio_i ? SM_OP : SM_IDLE;
                    cnt_nxt = 5'h00;
                end
                SM_OP:
                begin
                    op_nxt = {op_r[0], mdio_i};
                    if (cnt_r[0])
                    begin
                        cnt_nxt = 5'h00;
                        sm_nxt = SM_ADDR;
                    end
                end
                SM_ADDR:
                begin
                    addr_nxt = {addr_r[8:0], mdio_i};
                    if (cnt_r == SMI_ADDR_LAST)
                    begin
                        cnt_nxt = 5'h00;
                        sm_nxt = (op_r == SMI_OP_READ || op_r == SMI_OP_WRITE) ? SM_TA : SM_IDLE;
                    end
                end
                SM_TA:
                    if (cnt_r[0])
                    begin
                        cnt_nxt = 5'h00;
                        sm_nxt = SM_DATA;
                        case (addr_r)
                            REG_CTRL: sh_nxt = ctrl_r;
                            REG_STAT: sh_nxt = stat_val;
                            REG_ADV: sh_nxt = adv_eff;
                            REG_LPA: sh_nxt = lpa_r;
                            default: sh_nxt = 16'h0000;
                        endcase
                    end
                SM_DATA:
                begin
                    sh_nxt = {sh_r[14:0], mdio_i};
                    if (cnt_r == SMI_DATA_LAST)
                    begin
                        sm_nxt = SM_IDLE;
                        if (op_r == SMI_OP_WRITE && addr_r == REG_CTRL)
                        begin
                            ctrl_nxt[CTRL_SPEED] = sh_r[14 - (15 - CTRL_SPEED)];
                            ctrl_nxt[CTRL_AN_EN] = sh_r[14 - (15 - CTRL_AN_EN)];
                            ctrl_nxt[CTRL_DUPLEX] = sh_r[14 - (15 - CTRL_DUPLEX)];
                            restart_nxt = sh_r[14 - (15 - CTRL_RESTART)];
                        end
                        if (op_r == SMI_OP_WRITE && addr_r == REG_ADV)
                            adv_nxt = {sh_r[14:0], mdio_i};
                    end
                end
                default:
                    sm_nxt = SM_IDLE;
            endcase
        end
        // pin changes one cycle after the rising edge, the host samples on the next one
        oe_n_nxt = ~(op_r == SMI_OP_READ && ((sm_nxt == SM_TA && cnt_nxt[0]) || sm_nxt == SM_DATA));
        mdio_nxt = (sm_nxt == SM_DATA) ? sh_nxt[15] : 1'b0;
        if (reset_i)
        begin
            sm_nxt = SM_IDLE;
            cnt_nxt = 5'h00;
            op_nxt = 2'h0;
            addr_nxt = 10'h000;
            sh_nxt = 16'h0000;
            ctrl_nxt = 16'h0000;
            ctrl_nxt[CTRL_SPEED] = straps_i.speed_100;
            ctrl_nxt[CTRL_AN_EN] = straps_i.an_enable;
            ctrl_nxt[CTRL_DUPLEX] = straps_i.full_duplex;
            adv_nxt = ADV_RESET;
            oe_n_nxt = 1'b1;
            mdio_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        sm_r <= sm_nxt;
        mdc_q_r <= mdc_q_nxt;
        cnt_r <= cnt_nxt;
        op_r <= op_nxt;
        addr_r <= addr_nxt;
        sh_r <= sh_nxt;
        ctrl_r <= ctrl_nxt;
        adv_r <= adv_nxt;
        restart_r <= restart_nxt;
        mdio_r <= mdio_nxt;
        oe_n_r <= oe_n_nxt;
    end

    // ********************************
    // negotiation: pulse bursts out, words in, resolution
    // ********************************
    pan_an_state_type an_r, an_nxt;
    logic [15:0] sub_r, sub_nxt;
    logic [15:0] slot_r, slot_nxt;
    logic tx_r, tx_nxt;
    logic [15:0] gap_r, gap_nxt;
    logic in_burst_r, in_burst_nxt;
    logic clk_seen_r, clk_seen_nxt;
    logic [4:0] idx_r, idx_nxt;
    logic [15:0] word_r, word_nxt;
    logic [15:0] last_r, last_nxt;
    logic [1:0] match_r, match_nxt;
    logic [15:0] lpa_nxt;
    logic link_nxt;
    pan_mode_type mode_r, mode_nxt;
    logic [15:0] tx_word;
    logic word_valid;
    logic [3:0] common;

    always_comb
    begin
        an_done = (an_r == AN_DONE);
        link_nxt = link_ok_i;
        an_nxt = an_r;
        lpa_nxt = lpa_r;
        mode_nxt = mode_r;
        tx_word = adv_eff;
        tx_word[ADV_ACK] = (an_r == AN_ACK);
        // burst: even slots carry clock pulses, odd slots the word bits
        sub_nxt = sub_r + 16'h0001;
        slot_nxt = slot_r;
        if (sub_r == 16'(SLOT_CYC - 1))
        begin
            sub_nxt = 16'h0000;
            slot_nxt = (slot_r == 16'(INTERVAL_SLOTS - 1)) ? 16'h0000 : slot_r + 16'h0001;
        end
        tx_nxt = (an_r == AN_ABILITY || an_r == AN_ACK) && sub_r < 16'(FLP_PULSE_CYC) &&
            slot_r < 16'(FLP_BURST_SLOTS) && (!slot_r[0] || tx_word[slot_r[4:1]]);
        // receive: a pulse shortly after a clock pulse is a one
        gap_nxt = (gap_r == 16'(RX_END_CYC)) ? gap_r : gap_r + 16'h0001;
        in_burst_nxt = in_burst_r;
        clk_seen_nxt = clk_seen_r;
        idx_nxt = idx_r;
        word_nxt = word_r;
        word_valid = 1'b0;
        if (flp_rx_i)
        begin
            gap_nxt = 16'h0000;
            if (clk_seen_r && gap_r < 16'(FLP_DATA_MAX_CYC))
            begin
                word_nxt[idx_r[3:0]] = 1'b1;
                clk_seen_nxt = 1'b0;
            end
            else
            begin
                clk_seen_nxt = 1'b1;
                if (in_burst_r)
                    idx_nxt = idx_r + 5'h01;
                else
                begin
                    in_burst_nxt = 1'b1;
                    idx_nxt = 5'h00;
                    word_nxt = 16'h0000;
                end
            end
        end
        else if (in_burst_r && gap_r == 16'(RX_END_CYC))
        begin
            in_burst_nxt = 1'b0;
            clk_seen_nxt = 1'b0;
            word_valid = (idx_r == 5'(FLP_WORD_BITS));
        end
        last_nxt = last_r;
        match_nxt = match_r;
        if (word_valid)
        begin
            last_nxt = word_r;
            match_nxt = (word_r == last_r && match_r != MATCH_COUNT) ? match_r + 2'h1 :
                (word_r == last_r) ? match_r : 2'h1;
        end
        case (an_r)
            AN_OFF:
                if (ctrl_r[CTRL_AN_EN])
                    an_nxt = AN_ABILITY;
            AN_ABILITY:
                if (word_valid && word_r == last_r && match_r == MATCH_COUNT - 2'h1)
                    an_nxt = AN_ACK;
            AN_ACK:
                if (word_valid && word_r[ADV_ACK])
                begin
                    an_nxt = AN_DONE;
                    lpa_nxt = word_r;
                end
            AN_DONE:
                an_nxt = AN_DONE;
            default:
                an_nxt = AN_OFF;
        endcase
        if (!ctrl_r[CTRL_AN_EN])
            an_nxt = AN_OFF;
        else if (restart_r)
            an_nxt = AN_ABILITY;
        if (an_nxt == AN_ABILITY && an_r != AN_ABILITY)
        begin
            // fresh start: old partner words must not count toward a match
            match_nxt = 2'h0;
            sub_nxt = 16'h0000;
            slot_nxt = 16'h0000;
        end
        common = adv_eff[ABIL_100F:ABIL_10H] & lpa_r[ABIL_100F:ABIL_10H];
        if (!ctrl_r[CTRL_AN_EN])
        begin
            mode_nxt.speed_100 = ctrl_r[CTRL_SPEED];
            mode_nxt.full_duplex = ctrl_r[CTRL_DUPLEX];
        end
        else if (an_done)
        begin
            mode_nxt.speed_100 = common[3] | common[2];
            mode_nxt.full_duplex = common[3] | (~common[2] & common[1]);
        end
        if (reset_i)
        begin
            an_nxt = AN_OFF;
            sub_nxt = 16'h0000;
            slot_nxt = 16'h0000;
            tx_nxt = 1'b0;
            gap_nxt = 16'h0000;
            in_burst_nxt = 1'b0;
            clk_seen_nxt = 1'b0;
            idx_nxt = 5'h00;
            word_nxt = 16'h0000;
            last_nxt = 16'h0000;
            match_nxt = 2'h0;
            lpa_nxt = 16'h0000;
            link_nxt = 1'b0;
            mode_nxt = '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        an_r <= an_nxt;
        sub_r <= sub_nxt;
        slot_r <= slot_nxt;
        tx_r <= tx_nxt;
        gap_r <= gap_nxt;
        in_burst_r <= in_burst_nxt;
        clk_seen_r <= clk_seen_nxt;
        idx_r <= idx_nxt;
        word_r <= word_nxt;
        last_r <= last_nxt;
        match_r <= match_nxt;
        lpa_r <= lpa_nxt;
        link_r <= link_nxt;
        mode_r <= mode_nxt;
    end

    assign mdio_o = mdio_r;
    assign mdio_oe_n_o = oe_n_r;
    assign flp_tx_o = tx_r;
    assign mode_o = mode_r;
    assign port5_o = port5_r;
    assign port4_mode_o = port4_r;
endmodule : pan_autoneg
`default_nettype wire

// *** testbench/pan_chk.sv ***
// checker: port assertions of the auto-negotiation block
`timescale 1ns/100ps
`default_nettype none
module pan_chk #(
    parameter int SLOT_CYC = 20
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire pan_pkg::pan_strap_type straps_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic mdio_o,
    input wire logic mdio_oe_n_o,
    input wire logic flp_rx_i,
    input wire logic flp_tx_o,
    input wire logic link_ok_i,
    input wire pan_pkg::pan_mode_type mode_o,
    input wire pan_pkg::pan_port5_type port5_o,
    input wire pan_pkg::pan_port4_type port4_mode_o
);
    import pan_pkg::*;
    // ****
    // helper: cycles since last pulse rise
    // ****
    logic tx_r;
    int gap_r;
    int gap_nxt;
    // saturates so a long silence never wraps into a false short gap
    always_comb gap_nxt = (flp_tx_o && !tx_r) ? 0 : (gap_r < 9999 ? gap_r + 1 : gap_r);
    always_ff @(posedge clk_i)
    begin
        tx_r <= flp_tx_o;
        gap_r <= reset_i ? 9999 : gap_nxt;
    end
    // ****
    // properties
    // ****
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_two_reset;
        reset_i [*2];
    endsequence
    sequence s_one_pulse;
        flp_tx_o ##1 !flp_tx_o;
    endsequence
    sequence s_line_quiet;
        !flp_tx_o [*8];
    endsequence
    chk_reset_quiet: assert property (disable iff (1'b0) s_two_reset |->
        mdio_oe_n_o && !flp_tx_o && mode_o == '0)
        else $error("outputs active during reset");
    chk_port5_decode: assert property ($fell(reset_i) |-> ##2
        port5_o == {straps_i.port5_bus_select == 2'h0, !straps_i.port5_speed_strap, !straps_i.port5_duplex_strap,
        !straps_i.port5_link_strap})
        else $error("port 5 decode wrong");
    chk_port4_decode: assert property ($fell(reset_i) |-> ##2 port4_mode_o ==
        (straps_i.port4_pcs_select_strap ? P4_PCS_MII : (straps_i.port4_bus_select == 2'h1 ? P4_MAC_MII : P4_PHY)))
        else $error("port 4 decode wrong");
    chk_start_now: assert property ($fell(reset_i) && straps_i.an_enable |-> ##[1:6] flp_tx_o)
        else $error("negotiation did not start");
    chk_start_held: assert property ($fell(reset_i) && !straps_i.an_enable |-> s_line_quiet)
        else $error("pulses while negotiation off");
    chk_pulse_width: assert property ($rose(flp_tx_o) |=> s_one_pulse)
        else $error("pulse width not two cycles");
    chk_pulse_quiet: assert property ($fell(flp_tx_o) |-> s_line_quiet)
        else $error("pulses too close");
    chk_slot_gap: assert property ($rose(flp_tx_o) |-> gap_r >= SLOT_CYC - 1)
        else $error("pulse before slot end");
    chk_read_turn: assert property ($fell(mdio_oe_n_o) |-> !mdio_o && $past(mdc_i) && !$past(mdc_i, 2))
        else $error("turnaround drive wrong");
    chk_read_release: assert property ($rose(mdio_oe_n_o) |-> $past(mdc_i) && !$past(mdc_i, 2))
        else $error("data release not after clock rise");
endmodule : pan_chk
bind pan_autoneg pan_chk #(.SLOT_CYC(SLOT_CYC)) i_chk (.clk_i(clk_i), .reset_i(reset_i), .straps_i(straps_i),
    .mdc_i(mdc_i), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o), .flp_rx_i(flp_rx_i),
    .flp_tx_o(flp_tx_o), .link_ok_i(link_ok_i), .mode_o(mode_o), .port5_o(port5_o), .port4_mode_o(port4_mode_o));
`default_nettype wire

// *** testbench/pan_lp_model.sv ***
// link partner model: fast link pulse bursts toward the phy
`timescale 1ns/100ps
`default_nettype none
module pan_lp_model (
    input wire logic clk_i,
    output logic flp_o
);
    import pan_pkg::*;
    // ****
    // burst sender
    // ****
    initial flp_o = 1'b0;
    task automatic pulse;
        @(posedge clk_i);
        #1 flp_o = 1'b1;
        @(posedge clk_i);
        #1 flp_o = 1'b0;
    endtask : pulse
    // a one trails its clock pulse by 21 clks; a zero leaves a 2001-clk gap, past the
    // data window but short of the burst end; the 2200-clk tail closes each burst
    task automatic send(input logic [15:0] w, input int n);
        for (int b = 0; b < n; b++)
        begin
            for (int k = 0; k <= FLP_WORD_BITS; k++)
            begin
                pulse();
                if (k < FLP_WORD_BITS && w[k])
                begin
                    repeat (20) @(posedge clk_i);
                    pulse();
                    repeat (20) @(posedge clk_i);
                end
                else if (k < FLP_WORD_BITS)
                    repeat (2000) @(posedge clk_i);
                else
                    repeat (2200) @(posedge clk_i);
            end
        end
    endtask : send
endmodule : pan_lp_model
`default_nettype wire

// *** testbench/pan_autoneg_tb_top.sv ***
// testbench: straps, management registers and negotiation of the phy channel
`timescale 1ns/100ps
`default_nettype none
module pan_autoneg_tb_top;
    import pan_pkg::*;
    localparam int SLOT = 20;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    pan_strap_type straps_i = '1;
    logic mdc_i = 1'b0;
    logic tb_mdio = 1'b1;
    logic link_ok_i = 1'b0;
    logic mdio_o;
    logic mdio_oe_n_o;
    logic flp_rx_i;
    logic flp_tx_o;
    pan_mode_type mode_o;
    pan_port5_type port5_o;
    pan_port4_type port4_mode_o;
    pan_strap_type s;
    logic [15:0] ctl, adv, lpa, w;
    logic done;
    int errors = 0;
    int checks = 0;
    int p;
    // pull-up keeps the shared line high while nobody drives it
    wire logic mdio_w = mdio_oe_n_o ? tb_mdio : mdio_o;
    initial forever #25 clk_i = ~clk_i;
    pan_autoneg #(.SLOT_CYC(SLOT), .INTERVAL_SLOTS(40), .RX_END_CYC(2100)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
        .straps_i(straps_i), .mdc_i(mdc_i), .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o),
        .flp_rx_i(flp_rx_i), .flp_tx_o(flp_tx_o), .link_ok_i(link_ok_i), .mode_o(mode_o), .port5_o(port5_o),
        .port4_mode_o(port4_mode_o));
    pan_lp_model i_lp (.clk_i(clk_i), .flp_o(flp_rx_i));
    // ****
    // checking and bus tasks
    // ****
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    // frame with trailing idle bit; a read leaves ones, which the pull-up gives anyway
    task automatic smi(input logic [1:0] op, input logic [9:0] a, input logic [15:0] d, output logic [15:0] r);
        logic [32:0] f;
        f = {2'h1, op, a, 2'h2, d, 1'b1};
        for (int i = 0; i < 33; i++)
        begin
            tb_mdio = f[32 - i];
            mdc_i = 1'b0;
            cyc(2);
            if (i > 15 && i < 32)
                r[31 - i] = mdio_w;
            mdc_i = 1'b1;
            cyc(2);
        end
    endtask : smi
    task automatic rd(input logic [9:0] a, input logic [15:0] e, input string n);
        logic [15:0] v;
        smi(SMI_OP_READ, a, 16'hFFFF, v);
        chk(n, v, e);
    endtask : rd
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        logic [15:0] v;
        smi(SMI_OP_WRITE, a, d, v);
    endtask : wr
    // ****
    // reference model
    // ****
    function automatic logic [15:0] amask(input pan_strap_type t);
        logic [15:0] m;
        m = 16'hFE1F;
        for (int i = 0; i < 4; i++)
            if (t.an_enable ? ((i & ~{t.speed_100, t.full_duplex}) & 3) == 0 : i == {t.speed_100, t.full_duplex})
                m[5 + i] = 1'b1;
        return m;
    endfunction : amask
    function automatic logic [15:0] best(input logic [15:0] c);
        best = 16'h0000;
        for (int i = 0; i < 4; i++)
            if (c[5 + i])
                best = 16'(i);
    endfunction : best
    task automatic regs;
        rd(REG_CTRL, ctl, "control");
        rd(REG_STAT,
            STAT_FIXED | {10'h0, done, done & lpa[13], 1'b0, link_ok_i, 2'h0}, "status");
        rd(REG_ADV, adv & amask(s), "advert");
        rd(REG_LPA, lpa, "partner");
        rd(10'h002, 16'h0000, "unmapped");
    endtask : regs
    task automatic rst;
        straps_i = s;
        reset_i = 1'b1;
        cyc(20);
        reset_i = 1'b0;
        cyc(3);
        ctl = {2'h0, s.speed_100, s.an_enable, 3'h0, s.full_duplex, 8'h00};
        adv = ADV_RESET;
        lpa = 16'h0000;
        done = 1'b0;
        chk("port5", 16'(port5_o), {12'h0, s.port5_bus_select == 2'h0,
            !s.port5_speed_strap, !s.port5_duplex_strap, !s.port5_link_strap});
        chk("port4", 16'(port4_mode_o),
            s.port4_pcs_select_strap ? 16'h0002 : 16'(s.port4_bus_select == 2'h1));
    endtask : rst
    // waits for a pulse that follows at least q silent cycles
    task automatic wait_tx(input int q);
        int n;
        int z;
        n = 0;
        z = 0;
        while ((z < q || flp_tx_o !== 1'b1) && n < 5000)
        begin
            z = flp_tx_o ? 0 : z + 1;
            cyc(1);
            n++;
        end
        if (n == 5000)
        begin
            errors++;
            $display("mismatch tx_pulse expected 1 seen 0");
            end_sim();
        end
    endtask : wait_tx
    task automatic count_tx;
        p = 0;
        repeat (200)
        begin
            cyc(1);
            p += flp_tx_o;
        end
    endtask : count_tx
    // ****
    // scenarios
    // ****
    initial
    begin
        void'($urandom(32'h598D));
        for (int i = 0; i < 5; i++)
        begin
            s = pan_strap_type'($urandom);
            s.an_enable = (i == 4);
            s.speed_100 = i[1];
            s.full_duplex = i[0];
            link_ok_i = 1'($urandom);
            rst();
            regs();
            chk("mode", 16'(mode_o), s.an_enable ? 16'h0000 : 16'(i));
            count_tx();
            chk("tx_active", 16'(p != 0), 16'(s.an_enable));
        end
        $display("test straps done");
        s = pan_strap_type'($urandom);
        s.an_enable = 1'b1;
        s.speed_100 = 1'b1;
        s.full_duplex = 1'b1;
        rst();
        wr(REG_ADV, 16'h0161);
        adv = 16'h0161;
        wr(REG_STAT, 16'h0000);
        wr(REG_LPA, 16'hFFFF);
        wr(10'h002, 16'hFFFF);
        regs();
        wait_tx(3 * SLOT);
        w = 16'h0000;
        p = 1;
        for (int j = 1; j < 33; j++)
        begin
            cyc(SLOT);
            if (j % 2 == 1)
                w[(j - 1) / 2] = flp_tx_o;
            else
                p += flp_tx_o;
        end
        chk("burst_word", w, adv);
        chk("burst_clocks", 16'(p), 16'h0011);
        // partner lacks 100 full and the advertisement drops 100 half, so 10 full must win
        i_lp.send(16'h7EE1, 4);
        cyc(1);
        lpa = 16'h7EE1;
        done = 1'b1;
        chk("mode", 16'(mode_o), best(adv & lpa));
        regs();
        count_tx();
        chk("tx_after_done", 16'(p), 16'h0000);
        $display("test negotiation done");
        wr(REG_CTRL, 16'h0000);
        ctl = 16'h0000;
        cyc(2);
        chk("mode", 16'(mode_o), 16'h0000);
        wr(REG_CTRL, 16'hF3FF);
        ctl = 16'h3100;
        done = 1'b0;
        wait_tx(0);
        chk("mode", 16'(mode_o), 16'h0000);
        rd(REG_CTRL, ctl, "control");
        rd(REG_STAT, STAT_FIXED | {13'h0, link_ok_i, 2'h0}, "status");
        $display("test restart done");
        end_sim();
    end
endmodule : pan_autoneg_tb_top
`default_nettype wire
